//--- hdl/ppsc_regs.svh
`ifndef PPSC_REGS_SVH
`define PPSC_REGS_SVH

// register indices; the byte address is four times the index
`define PPSC_IDX_CTRL    6'h00
`define PPSC_IDX_MASK    6'h01
`define PPSC_IDX_VMASK   6'h02
`define PPSC_IDX_SLPCFG  6'h03
`define PPSC_IDX_DPCFG   6'h04
`define PPSC_IDX_STATUS  6'h05

// control register bit positions
`define PPSC_B_SLP_REQ   0
`define PPSC_B_SLP_ARM   1
`define PPSC_B_DP_REQ    2
`define PPSC_B_DP_ARM    3
`define PPSC_B_INHIBIT   4
// thermal interrupt mask position in the mask register
`define PPSC_B_TMASK     5
// field positions inside the vmask and config registers
`define PPSC_F_HI        8

// fixed defaults of the volatile registers
`define PPSC_CTRL_RST    5'h00
`define PPSC_TMASK_RST   1'h0
`define PPSC_UVMASK_RST  5'h00
`define PPSC_OVMASK_RST  5'h00
// factory defaults of the programmable registers
`define PPSC_SLPON_RST   5'h1f
`define PPSC_SLPALT_RST  3'h7
`define PPSC_DPON_RST    5'h00
`define PPSC_DPALT_RST   3'h0

// axi responses
`define PPSC_RESP_OKAY   2'h0
`define PPSC_RESP_SLVERR 2'h2

// timing
`define PPSC_CLK_MHZ     200
`define PPSC_RETRY_MS    100
`define PPSC_RETRY_CYC   (`PPSC_RETRY_MS * 1000 * `PPSC_CLK_MHZ)

`endif

//--- hdl/ppsc_pkg.sv
package ppsc_pkg;

  // power states of the controller
  typedef enum logic [2:0] {
    ST_RESET  = 3'h0,
    ST_SEQ    = 3'h1,
    ST_ACTIVE = 3'h2,
    ST_SLEEP  = 3'h3,
    ST_DEEP   = 3'h4,
    ST_THERM  = 3'h5,
    ST_VFAULT = 3'h6
  } ppsc_state_e;

  // asynchronous monitor inputs; bits [2:0] bucks, [4:3] linears
  typedef struct packed {
    logic       supply_low;
    logic       supply_high;
    logic       thermal_trip;
    logic       power_enable_pin;
    logic [4:0] reg_ov;
    logic [4:0] reg_uv;
    logic [4:0] ss_done;
  } ppsc_mon_s;

  // power outputs
  typedef struct packed {
    logic [4:0] reg_on;
    logic [2:0] buck_alt;
    logic [2:0] reset_n;
    logic       interrupt_out_n;
    logic       host_if_en;
    logic       host_if_flush;
  } ppsc_pwr_s;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } ppsc_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } ppsc_axi_rsp_s;

  // complete state of the controller
  typedef struct packed {
    ppsc_state_e st;
    logic [24:0] timer;
    logic        pin_prev;
    logic [1:0]  pin_seen;  // enabled edges since reset, saturating at 3
    logic        deep_pin;
    logic [4:0]  ctrl;
    logic        tmask;
    logic [4:0]  uv_mask;
    logic [4:0]  ov_mask;
    logic [4:0]  slp_on;
    logic [2:0]  slp_alt;
    logic [4:0]  dp_on;
    logic [2:0]  dp_alt;
    ppsc_pwr_s   pwr;
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ppsc_state_s;

endpackage : ppsc_pkg

//--- hdl/ppsc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser; the first stage feeds only the second
module ppsc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;  // may go metastable
    logic [W-1:0] stab;  // safe to read
  } ppsc_sync_s;

  ppsc_sync_s q;
  ppsc_sync_s d;

  // shift one stage per enabled edge
  always_comb
  begin
    d.meta = async_in;
    d.stab = q.meta;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else if (ce)
      q <= d;
  end

  assign sync_out = q.stab;

endmodule : ppsc_sync

`default_nettype wire

//--- hdl/ppsc_top.sv
// Functional notes
// [RULE1] reset state: regulators off, resets low
// [RULE2] reset state restores all register defaults
// [RULE3] supply in range leaves reset
// [RULE4] supply below low threshold forces reset
// [RULE5] active: all outputs on, no fault
// [RULE6] sleep uses each output's sleep setting
// [RULE7] sleep: bucks primary/alternate/off, linears primary/off
// [RULE8] sleep while request and arm both set
// [RULE9] host interface runs in sleep states
// [RULE10] deep sleep from bits or pin, own settings
// [RULE11] fault in deep sleep returns to active
// [RULE12] pin rising edge sets deep sleep arm
// [RULE13] armed pin falling edge enters deep sleep
// [RULE14] host toggles pin if high at power-up
// [RULE15] fault exit clears arm, needs fresh edges
// [RULE16] over temperature: thermal state, all off
// [RULE17] thermal mask blocks interrupt, not state
// [RULE18] regulator ov or late uv: fault state
// [RULE19] fault state retries active after 100ms
// [RULE20] inhibit bit blocks voltage fault state
// [RULE21] over-current acts only through under-voltage
// [RULE22] voltage masks block interrupt, status readable
// [RULE23] flush host interface entering low/fault states
// [RULE24] host interface off only in reset
// [RULE25] pin synchronised, one pulse per edge
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

`include "ppsc_regs.svh"

module ppsc_top #(
  parameter int unsigned RETRY_CYCLES = `PPSC_RETRY_CYC
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     ce,
  input  wire ppsc_pkg::ppsc_mon_s      mon,
  input  wire ppsc_pkg::ppsc_axi_req_s  axi_req,
  output ppsc_pkg::ppsc_axi_rsp_s       axi_rsp,
  output ppsc_pkg::ppsc_pwr_s           pwr
);

  // retry wait, counted down to zero in the fault state
  localparam logic [24:0] RETRY_LOAD = 25'(RETRY_CYCLES - 1);

  ppsc_pkg::ppsc_state_s q;          // registered state
  ppsc_pkg::ppsc_state_s d;          // next state
  ppsc_pkg::ppsc_mon_s   m;          // synchronised monitors
  logic                  rise;       // pin rising edge event
  logic                  fall;       // pin falling edge event
  logic                  vf_raw;     // regulator voltage fault
  logic                  vf_go;      // fault not inhibited
  logic                  sys_flt;    // fault that ends deep sleep
  logic                  deep_cond;  // deep sleep entry holds
  logic                  sleep_cond; // sleep entry holds
  logic                  awready;    // write address accepted
  logic                  wready;     // write data accepted
  logic                  arready;    // read address accepted
  logic [31:0]           wr_val;     // merged write value
  logic [5:0]            wr_idx;     // write register index

  // every monitor is asynchronous, so all pass two flops
  ppsc_sync #(
    .W ($bits(ppsc_pkg::ppsc_mon_s))
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .async_in (mon),
    .sync_out (m)
  );

  // index lies inside the map
  function automatic logic ppsc_hit(input logic [7:0] addr);
    ppsc_hit = addr[7:2] <= `PPSC_IDX_STATUS;
  endfunction : ppsc_hit

  // byte lane merge of a write into the old value
  function automatic logic [31:0] ppsc_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    ppsc_merge = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        ppsc_merge[i*8 +: 8] = new_v[i*8 +: 8];
  endfunction : ppsc_merge

  // register read mux; unused bits read zero
  function automatic logic [31:0] ppsc_rd(
    input ppsc_pkg::ppsc_state_s s,
    input ppsc_pkg::ppsc_mon_s   mv,
    input logic [5:0]            idx
  );
    ppsc_rd = 32'h0;
    case (idx)
      `PPSC_IDX_CTRL:   ppsc_rd[4:0] = s.ctrl;
      `PPSC_IDX_MASK:   ppsc_rd[`PPSC_B_TMASK] = s.tmask;
      `PPSC_IDX_VMASK:
      begin
        ppsc_rd[4:0] = s.uv_mask;
        ppsc_rd[`PPSC_F_HI +: 5] = s.ov_mask;
      end
      `PPSC_IDX_SLPCFG:
      begin
        ppsc_rd[4:0] = s.slp_on;
        ppsc_rd[`PPSC_F_HI +: 3] = s.slp_alt;
      end
      `PPSC_IDX_DPCFG:
      begin
        ppsc_rd[4:0] = s.dp_on;
        ppsc_rd[`PPSC_F_HI +: 3] = s.dp_alt;
      end
      `PPSC_IDX_STATUS:
      begin
        // fault status stays visible even when masked
        ppsc_rd[2:0]   = s.st;
        ppsc_rd[12:8]  = mv.reg_uv; // [RULE22]
        ppsc_rd[20:16] = mv.reg_ov; // [RULE22]
        ppsc_rd[24]    = mv.thermal_trip;
        ppsc_rd[25]    = mv.supply_low;
        ppsc_rd[26]    = mv.supply_high;
      end
      default:          ppsc_rd = 32'h0;
    endcase
  endfunction : ppsc_rd

  // whole controller: bus slave, pin edges, power state machine
  always_comb
  begin
    d = q;
    d.pwr.host_if_flush = 1'b0;

    // the synchroniser shows its reset zero for two edges, so edges
    // count only once pin_prev holds a true sample; a pin high at
    // power-up is then not mistaken for a rising edge
    rise = (q.pin_seen == 2'h3) & m.power_enable_pin
         & ~q.pin_prev; // [RULE25]
    fall = (q.pin_seen == 2'h3) & ~m.power_enable_pin
         & q.pin_prev; // [RULE25]
    d.pin_prev = m.power_enable_pin;
    if (q.pin_seen != 2'h3)
      d.pin_seen = q.pin_seen + 2'h1;

    // over-current has no input here; it shows up as uv
    vf_raw  = (|m.reg_ov) | (|(m.reg_uv & m.ss_done)); // [RULE18] [RULE21]
    vf_go   = vf_raw & ~q.ctrl[`PPSC_B_INHIBIT]; // [RULE20]
    sys_flt = m.thermal_trip | vf_raw | m.supply_high;
    deep_cond  = q.ctrl[`PPSC_B_DP_ARM]
               & (q.ctrl[`PPSC_B_DP_REQ] | q.deep_pin); // [RULE10]
    // the pin plays no part in sleep entry
    sleep_cond = q.ctrl[`PPSC_B_SLP_REQ]
               & q.ctrl[`PPSC_B_SLP_ARM]; // [RULE8]

    // bus handshakes; one write and one read in flight
    awready = ~q.aw_have & ~q.bvalid;
    wready  = ~q.w_have & ~q.bvalid;
    arready = ~q.rvalid;
    wr_idx  = q.aw_addr[7:2];
    wr_val  = ppsc_merge(ppsc_rd(q, m, wr_idx), q.wdata, q.wstrb);

    if (axi_req.awvalid && awready)
    begin
      d.aw_have = 1'b1;
      d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && wready)
    begin
      d.w_have = 1'b1;
      d.wdata  = axi_req.wdata;
      d.wstrb  = axi_req.wstrb;
    end
    // both halves present: commit and answer
    if (q.aw_have && q.w_have)
    begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = ppsc_hit(q.aw_addr) ? `PPSC_RESP_OKAY
                                      : `PPSC_RESP_SLVERR;
      // writes in reset are answered but dropped
      if (ppsc_hit(q.aw_addr) && q.st != ppsc_pkg::ST_RESET) // [RULE24]
      begin
        case (wr_idx)
          `PPSC_IDX_CTRL:   d.ctrl  = wr_val[4:0];
          `PPSC_IDX_MASK:   d.tmask = wr_val[`PPSC_B_TMASK];
          `PPSC_IDX_VMASK:
          begin
            d.uv_mask = wr_val[4:0];
            d.ov_mask = wr_val[`PPSC_F_HI +: 5];
          end
          `PPSC_IDX_SLPCFG:
          begin
            d.slp_on  = wr_val[4:0];
            d.slp_alt = wr_val[`PPSC_F_HI +: 3];
          end
          `PPSC_IDX_DPCFG:
          begin
            d.dp_on  = wr_val[4:0];
            d.dp_alt = wr_val[`PPSC_F_HI +: 3];
          end
          default:          d.ctrl = d.ctrl; // status is read only
        endcase
      end
    end
    if (q.bvalid && axi_req.bready)
      d.bvalid = 1'b0;
    if (axi_req.arvalid && arready)
    begin
      d.rvalid = 1'b1;
      d.rdata  = ppsc_rd(q, m, axi_req.araddr[7:2]);
      d.rresp  = ppsc_hit(axi_req.araddr) ? `PPSC_RESP_OKAY
                                          : `PPSC_RESP_SLVERR;
    end
    if (q.rvalid && axi_req.rready)
      d.rvalid = 1'b0;

    // armed falling edge latches a pin request for deep sleep
    if (fall && q.ctrl[`PPSC_B_DP_ARM])
      d.deep_pin = 1'b1; // [RULE13]
    if (q.timer != 25'h0)
      d.timer = q.timer - 25'h1;

    // power state machine; supply drop beats all else
    if (q.st != ppsc_pkg::ST_RESET && m.supply_low)
      d.st = ppsc_pkg::ST_RESET; // [RULE4]
    else
    begin
      unique case (q.st)
        ppsc_pkg::ST_RESET:
          // wait for the supply window
          if (!m.supply_low && !m.supply_high)
            d.st = ppsc_pkg::ST_SEQ; // [RULE3]
        ppsc_pkg::ST_THERM:
          // restart through sequencing once cooled
          if (!m.thermal_trip)
            d.st = ppsc_pkg::ST_SEQ;
        ppsc_pkg::ST_VFAULT:
          // timed retry; a lasting fault comes straight back
          if (m.thermal_trip)
            d.st = ppsc_pkg::ST_THERM;
          else if (q.timer == 25'h0)
            d.st = ppsc_pkg::ST_ACTIVE; // [RULE19]
        ppsc_pkg::ST_DEEP:
          if (sys_flt)
          begin
            // fault exit disarms; new pin edges are needed
            d.st       = ppsc_pkg::ST_ACTIVE; // [RULE11]
            d.ctrl[`PPSC_B_DP_ARM] = 1'b0; // [RULE15]
            d.deep_pin = 1'b0; // [RULE15]
          end
          else if (!deep_cond)
            d.st = sleep_cond ? ppsc_pkg::ST_SLEEP
                              : ppsc_pkg::ST_ACTIVE; // [RULE10]
        ppsc_pkg::ST_SEQ,
        ppsc_pkg::ST_ACTIVE,
        ppsc_pkg::ST_SLEEP:
          if (m.thermal_trip)
            d.st = ppsc_pkg::ST_THERM; // [RULE16]
          else if (vf_go)
            d.st = ppsc_pkg::ST_VFAULT; // [RULE18]
          else if (deep_cond)
            d.st = ppsc_pkg::ST_DEEP; // [RULE10]
          else if (sleep_cond)
            d.st = ppsc_pkg::ST_SLEEP; // [RULE8]
          else
            d.st = ppsc_pkg::ST_ACTIVE; // [RULE5]
        default:
          d.st = ppsc_pkg::ST_RESET;
      endcase
    end

    // rising edge arms after the state logic, so set wins
    if (rise)
    begin
      d.ctrl[`PPSC_B_DP_ARM] = 1'b1; // [RULE12]
      d.deep_pin = 1'b0;
    end
    if (d.st == ppsc_pkg::ST_VFAULT && q.st != ppsc_pkg::ST_VFAULT)
      d.timer = RETRY_LOAD; // [RULE19]

    // any time in reset holds every register at its default
    if (d.st == ppsc_pkg::ST_RESET)
    begin
      d.ctrl     = `PPSC_CTRL_RST; // [RULE2]
      d.tmask    = `PPSC_TMASK_RST; // [RULE2]
      d.uv_mask  = `PPSC_UVMASK_RST;
      d.ov_mask  = `PPSC_OVMASK_RST;
      d.slp_on   = `PPSC_SLPON_RST; // [RULE2]
      d.slp_alt  = `PPSC_SLPALT_RST;
      d.dp_on    = `PPSC_DPON_RST;
      d.dp_alt   = `PPSC_DPALT_RST;
      d.deep_pin = 1'b0;
    end

    // regulator and reset pins follow the next state
    case (d.st)
      ppsc_pkg::ST_ACTIVE:
      begin
        d.pwr.reg_on   = 5'h1f; // [RULE5]
        d.pwr.buck_alt = 3'h0;
        d.pwr.reset_n  = 3'h7;
      end
      ppsc_pkg::ST_SLEEP:
      begin
        // linears have no alternate select at all
        d.pwr.reg_on   = q.slp_on; // [RULE6]
        d.pwr.buck_alt = q.slp_alt & q.slp_on[2:0]; // [RULE7]
        d.pwr.reset_n  = 3'h7;
      end
      ppsc_pkg::ST_DEEP:
      begin
        d.pwr.reg_on   = q.dp_on; // [RULE10]
        d.pwr.buck_alt = q.dp_alt & q.dp_on[2:0];
        d.pwr.reset_n  = 3'h7;
      end
      ppsc_pkg::ST_SEQ:
      begin
        // regulators ramp while resets are still held
        d.pwr.reg_on   = 5'h1f;
        d.pwr.buck_alt = 3'h0;
        d.pwr.reset_n  = 3'h0;
      end
      default:
      begin
        // reset, thermal and voltage fault: all off
        d.pwr.reg_on   = 5'h00; // [RULE1] [RULE16] [RULE18]
        d.pwr.buck_alt = 3'h0;
        d.pwr.reset_n  = 3'h0; // [RULE1] [RULE16] [RULE18]
      end
    endcase

    // masks gate only the interrupt, never the states
    d.pwr.interrupt_out_n = ~((m.thermal_trip & ~q.tmask)
                            | (|(m.reg_uv & ~q.uv_mask))
                            | (|(m.reg_ov & ~q.ov_mask))); // [RULE17] [RULE22]
    // bus stays up in sleep, deep sleep and faults
    d.pwr.host_if_en = d.st != ppsc_pkg::ST_RESET; // [RULE9] [RULE24]
    // drop any transfer in flight on these entries
    if (d.st != q.st && (d.st == ppsc_pkg::ST_SLEEP
        || d.st == ppsc_pkg::ST_DEEP || d.st == ppsc_pkg::ST_VFAULT
        || d.st == ppsc_pkg::ST_THERM))
      d.pwr.host_if_flush = 1'b1; // [RULE23]
  end

  // state register; ce low freezes everything
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q          <= '0;
      q.st       <= ppsc_pkg::ST_RESET;
      q.pwr.interrupt_out_n <= 1'b1;
      q.slp_on   <= `PPSC_SLPON_RST;
      q.slp_alt  <= `PPSC_SLPALT_RST;
      q.dp_on    <= `PPSC_DPON_RST;
      q.dp_alt   <= `PPSC_DPALT_RST;
    end
    else if (ce)
      q <= d;
  end

  // outputs
  assign pwr             = q.pwr;
  assign axi_rsp.awready = awready;
  assign axi_rsp.wready  = wready;
  assign axi_rsp.arready = arready;
  assign axi_rsp.bvalid  = q.bvalid;
  assign axi_rsp.bresp   = q.bresp;
  assign axi_rsp.rvalid  = q.rvalid;
  assign axi_rsp.rdata   = q.rdata;
  assign axi_rsp.rresp   = q.rresp;

  // checks; a frozen clock enable aborts them
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  reset_outputs_a: assert property ( // [RULE1]
    q.st == ppsc_pkg::ST_RESET |-> q.pwr.reg_on == 5'h00
      && q.pwr.reset_n == 3'h0)
    else $error("outputs live in reset");
  reset_defaults_a: assert property ( // [RULE2]
    q.st == ppsc_pkg::ST_RESET |-> q.ctrl == `PPSC_CTRL_RST
      && q.slp_on == `PPSC_SLPON_RST && q.dp_on == `PPSC_DPON_RST)
    else $error("defaults not restored in reset");
  leave_reset_a: assert property ( // [RULE3]
    q.st == ppsc_pkg::ST_RESET && !m.supply_low && !m.supply_high
      |=> q.st == ppsc_pkg::ST_SEQ)
    else $error("reset not left with supply in range");
  supply_drop_a: assert property ( // [RULE4]
    q.st != ppsc_pkg::ST_RESET && m.supply_low
      |=> q.st == ppsc_pkg::ST_RESET)
    else $error("supply drop missed");
  active_outputs_a: assert property ( // [RULE5]
    q.st == ppsc_pkg::ST_ACTIVE |-> q.pwr.reg_on == 5'h1f
      && q.pwr.reset_n == 3'h7 && q.pwr.buck_alt == 3'h0)
    else $error("active outputs wrong");
  sleep_outputs_a: assert property ( // [RULE6]
    q.st == ppsc_pkg::ST_SLEEP && $stable(q.st) |->
      q.pwr.reg_on == $past(q.slp_on)
      && q.pwr.buck_alt == ($past(q.slp_alt) & $past(q.slp_on[2:0])))
    else $error("sleep outputs wrong");
  sleep_entry_a: assert property ( // [RULE8]
    q.st == ppsc_pkg::ST_ACTIVE && sleep_cond && !deep_cond
      && !m.supply_low && !m.thermal_trip && !vf_go
      |=> q.st == ppsc_pkg::ST_SLEEP)
    else $error("sleep not entered");
  deep_fault_exit_a: assert property ( // [RULE11]
    q.st == ppsc_pkg::ST_DEEP && !m.supply_low && sys_flt
      |=> q.st == ppsc_pkg::ST_ACTIVE)
    else $error("deep sleep fault exit missed");
  disarm_a: assert property ( // [RULE15]
    q.st == ppsc_pkg::ST_DEEP && !m.supply_low && sys_flt && !rise
      |=> !q.ctrl[`PPSC_B_DP_ARM] ##1 q.st != ppsc_pkg::ST_DEEP)
    else $error("arm kept after fault exit");
  arm_on_rise_a: assert property ( // [RULE12]
    rise && !m.supply_low && q.st != ppsc_pkg::ST_RESET
      |=> q.ctrl[`PPSC_B_DP_ARM])
    else $error("rising edge did not arm");
  thermal_off_a: assert property ( // [RULE16]
    q.st == ppsc_pkg::ST_ACTIVE && m.thermal_trip && !m.supply_low
      |=> q.st == ppsc_pkg::ST_THERM && q.pwr.reg_on == 5'h00)
    else $error("thermal shutdown missed");
  tmask_quiet_a: assert property ( // [RULE17]
    q.tmask && (&q.uv_mask) && (&q.ov_mask) && $stable(q.tmask)
      |=> q.pwr.interrupt_out_n)
    else $error("masked fault raised interrupt");
  retry_a: assert property ( // [RULE19]
    q.st == ppsc_pkg::ST_VFAULT && q.timer == 25'h0
      && !m.supply_low && !m.thermal_trip
      |=> q.st == ppsc_pkg::ST_ACTIVE)
    else $error("fault retry missed");
  inhibit_a: assert property ( // [RULE20]
    q.st != ppsc_pkg::ST_VFAULT && q.ctrl[`PPSC_B_INHIBIT]
      |=> q.st != ppsc_pkg::ST_VFAULT)
    else $error("inhibited fault entered");
  flush_a: assert property ( // [RULE23]
    $changed(q.st) && q.st == ppsc_pkg::ST_SLEEP
      |-> q.pwr.host_if_flush
          ##1 (!q.pwr.host_if_flush || $changed(q.st)))
    else $error("flush pulse wrong");
  edge_once_a: assert property ( // [RULE25]
    rise |=> !rise)
    else $error("double edge event");

  sleep_c:  cover property (q.st == ppsc_pkg::ST_SLEEP);
  deep_c:   cover property (fall && q.ctrl[`PPSC_B_DP_ARM]
                            ##1 q.st == ppsc_pkg::ST_DEEP);
  retry_c:  cover property (q.st == ppsc_pkg::ST_VFAULT
                            ##1 q.st == ppsc_pkg::ST_ACTIVE);
  therm_c:  cover property (q.st == ppsc_pkg::ST_THERM);

endmodule : ppsc_top

`default_nettype wire

//--- verif/ppsc_host.sv
`timescale 1ns/1ps
`default_nettype none

// host model: register bus master plus the enable pin
module ppsc_host (
  input  wire logic                    aclk,
  output ppsc_pkg::ppsc_axi_req_s      req,
  input  wire ppsc_pkg::ppsc_axi_rsp_s rsp,
  output logic                         pin
);
  logic [1:0] wr_resp;  // response code of the last write

  // ready for answers at all times; pin low so the first rise arms
  initial
  begin
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    pin = 1'b0;
  end

  // one write: address and data offered together, each dropped when taken
  task automatic wr(input logic [5:0] i, input logic [31:0] v);
    logic a;
    logic w;
    a = 1'b0;
    w = 1'b0;
    req.awaddr <= {i, 2'h0};
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    while (!(a && w))
    begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      a = a | rsp.awready;
      w = w | rsp.wready;
    end
    do @(posedge aclk); while (!rsp.bvalid);
    wr_resp = rsp.bresp;
  endtask : wr

  // one read; data and response taken at the rvalid edge
  task automatic rd(input logic [5:0] i, output logic [31:0] v,
                    output logic [1:0] r);
    req.araddr <= {i, 2'h0};
    req.arvalid <= 1'b1;
    do @(posedge aclk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    do @(posedge aclk); while (!rsp.rvalid);
    v = rsp.rdata;
    r = rsp.rresp;
  endtask : rd

  // pin moves just after an edge
  task automatic set_pin(input logic v);
    @(posedge aclk);
    pin <= v;
  endtask : set_pin
endmodule : ppsc_host
`default_nettype wire

//--- verif/test_ppsc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppsc_regs.svh"

module test_ppsc_top;
  logic                    aclk = 1'b0;
  logic                    aresetn = 1'b0;
  ppsc_pkg::ppsc_mon_s     m;
  ppsc_pkg::ppsc_mon_s     mc;
  ppsc_pkg::ppsc_axi_req_s req;
  ppsc_pkg::ppsc_axi_rsp_s rsp;
  ppsc_pkg::ppsc_pwr_s     pwr;
  logic                    pin;
  logic [31:0]             d;
  logic [1:0]              r;
  int                      err_count = 0;
  int                      checks_done = 0;
  int                      cyc = 0;
  int                      flushes = 0;
  int                      on;
  int                      alt;

  always #2.5 aclk = ~aclk;

  // monitor word with the host's pin merged in
  always_comb
  begin
    mc = m;
    mc.power_enable_pin = pin;
  end

  ppsc_top #(.RETRY_CYCLES(20)) dut (.aclk(aclk), .aresetn(aresetn),
    .ce(1'b1), .mon(mc), .axi_req(req), .axi_rsp(rsp), .pwr(pwr));
  ppsc_host h (.aclk(aclk), .req(req), .rsp(rsp), .pin(pin));

  // count flush pulses; a hang ends the run as a failure
  always @(posedge aclk)
  begin
    cyc++;
    if (pwr.host_if_flush === 1'b1) flushes++;
    if (cyc == 20000)
    begin
      err_count++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    if (err_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // model: outputs and status code each power state except ST_SEQ should show
  task automatic expect_st(input int st, input int o, input int a);
    logic [10:0] e;
    case (st)
      2: e = {5'h1f, 3'h0, 3'h7};
      3, 4: e = {o[4:0], a[2:0] & o[2:0], 3'h7};
      default: e = 11'h000;
    endcase
    // three edges of sync and state, plus margin
    repeat (6) @(posedge aclk);
    check({pwr.reg_on, pwr.buck_alt, pwr.reset_n}, e);
    h.rd(`PPSC_IDX_STATUS, d, r);
    check(d[2:0], st[2:0]);
  endtask : expect_st

  initial
  begin
    m = '0;
    void'($urandom(27));
    repeat (5) @(posedge aclk);
    check({pwr.reg_on, pwr.reset_n, pwr.host_if_en}, 9'h0);
    aresetn <= 1'b1;
    expect_st(2, 0, 0);
    h.rd(`PPSC_IDX_SLPCFG, d, r);
    check(d, 32'h71f);
    // outside the map: error answer, read zero, write dropped
    h.rd(6'h06, d, r);
    check(d, 32'h0);
    check(r, 2'h2);
    h.wr(6'h06, 32'h1);
    check(h.wr_resp, 2'h2);
    // random sleep configuration
    on = $urandom % 32;
    alt = $urandom % 8;
    h.wr(`PPSC_IDX_SLPCFG, (32'(alt) << 8) | 32'(on));
    check(h.wr_resp, 2'h0);
    h.wr(`PPSC_IDX_CTRL, 32'h1);
    expect_st(2, 0, 0);
    h.wr(`PPSC_IDX_CTRL, 32'h3);
    expect_st(3, on, alt);
    check(flushes, 1);
    h.wr(`PPSC_IDX_CTRL, 32'h0);
    expect_st(2, 0, 0);
    // deep sleep by the pin, then a fault exit
    h.set_pin(1'b1);
    repeat (6) @(posedge aclk);
    h.rd(`PPSC_IDX_CTRL, d, r);
    check(d, 32'h8);
    h.set_pin(1'b0);
    expect_st(4, 0, 0);
    m.supply_high <= 1'b1;
    expect_st(2, 0, 0);
    m.supply_high <= 1'b0;
    h.rd(`PPSC_IDX_CTRL, d, r);
    check(d, 32'h0);
    // thermal with the interrupt masked, then unmasked
    h.wr(`PPSC_IDX_MASK, 32'h20);
    m.thermal_trip <= 1'b1;
    expect_st(5, 0, 0);
    check(pwr.interrupt_out_n, 1'b1);
    h.wr(`PPSC_IDX_MASK, 32'h0);
    repeat (2) @(posedge aclk);
    check(pwr.interrupt_out_n, 1'b0);
    m.thermal_trip <= 1'b0;
    expect_st(2, 0, 0);
    // undervoltage counts only once the ramp is done
    m.reg_uv <= 5'h04;
    expect_st(2, 0, 0);
    m.ss_done <= 5'h1f;
    expect_st(6, 0, 0);
    m.reg_uv <= 5'h00;
    repeat (4) @(posedge aclk);
    check(pwr.reg_on, 5'h00);
    // fault entered three edges after the ramp flag; 20 cycles there
    repeat (10) @(posedge aclk);
    check(pwr.reg_on, 5'h00);
    repeat (2) @(posedge aclk);
    check(pwr.reg_on, 5'h1f);
    expect_st(2, 0, 0);
    // inhibit, then masked overvoltage still faults
    h.wr(`PPSC_IDX_CTRL, 32'h10);
    m.reg_ov <= 5'h02;
    expect_st(2, 0, 0);
    check(pwr.interrupt_out_n, 1'b0);
    h.wr(`PPSC_IDX_VMASK, 32'h200);
    repeat (2) @(posedge aclk);
    check(pwr.interrupt_out_n, 1'b1);
    h.rd(`PPSC_IDX_STATUS, d, r);
    check(d[20:16], 5'h02);
    h.wr(`PPSC_IDX_CTRL, 32'h0);
    expect_st(6, 0, 0);
    m.reg_ov <= 5'h00;
    // supply drop restores every default
    m.supply_low <= 1'b1;
    expect_st(0, 0, 0);
    check(pwr.host_if_en, 1'b0);
    m.supply_low <= 1'b0;
    expect_st(2, 0, 0);
    h.rd(`PPSC_IDX_SLPCFG, d, r);
    check(d, 32'h71f);
    h.rd(`PPSC_IDX_VMASK, d, r);
    check(d, 32'h0);
    // second reset with the pin high: no arm until it is toggled
    h.set_pin(1'b1);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    expect_st(2, 0, 0);
    h.rd(`PPSC_IDX_CTRL, d, r);
    check(d, 32'h0);
    h.set_pin(1'b0);
    h.set_pin(1'b1);
    repeat (6) @(posedge aclk);
    h.rd(`PPSC_IDX_CTRL, d, r);
    check(d, 32'h8);
    results();
  end
endmodule : test_ppsc_top
`default_nettype wire
